// ==== common/mclc_pkg.sv ====
// Constants shared by the media converter link control block
package mclc_pkg;
    // Clock and indicator timing
    localparam int CLK_HZ       = 20_000_000;
    localparam int FLASH_MS     = 50;
    localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
    localparam int CNT_W        = 20;
    localparam int SYNC_DLY     = 3;
    localparam int DLY_W        = 2;

    // Configuration switch positions, 1 = ON
    localparam int NUM_SW    = 6;
    localparam int SW_NEG    = 0;
    localparam int SW_SPEED  = 1;
    localparam int SW_DUPLEX = 2;
    localparam int SW_PAUSE  = 3;
    localparam int SW_UNUSED = 4;
    localparam int SW_PROP   = 5;

    // Register byte offsets
    localparam logic [7:0] REG_CONFIG  = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_CONTROL = 8'h08;

    // Control fields and reset value
    localparam int          CTRL_LED_EN = 0;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0001;

    // Status bit positions
    localparam int ST_CU_LINK  = 0;
    localparam int ST_CU_100   = 1;
    localparam int ST_CU_FULL  = 2;
    localparam int ST_FX_LIGHT = 3;
    localparam int ST_FAR_FLT  = 4;
    localparam int ST_LFP_DOWN = 5;
    localparam int ST_REM_FLT  = 6;
    localparam int ST_CFG_DONE = 7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hw/mclc_top.sv ====
// Link control, indicators and register slave of the media converter
`timescale 1ns/10ps
`default_nettype none
module mclc_top
    import mclc_pkg::*;
#(
    parameter int FLASH_CYCLES_P = FLASH_CYCLES
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [NUM_SW-1:0] switch_on,
    input  wire logic              cu_link_up,
    input  wire logic              cu_speed_100,
    input  wire logic              cu_full_duplex,
    input  wire logic              cu_activity,
    input  wire logic              fx_light,
    input  wire logic              fx_activity,
    input  wire logic              fx_fault_rx,
    output logic                   cu_autoneg_en,
    output logic                   cu_fixed_100,
    output logic                   cu_fixed_full,
    output logic                   pause_en,
    output logic                   cu_link_enable,
    output logic                   fx_tx_enable,
    output logic                   fx_fault_tx,
    output logic                   led_cu_yellow,
    output logic                   led_cu_green,
    output logic                   led_duplex,
    output logic                   led_fx_link,
    output logic                   led_remote_fault
);
    localparam int NIN = 7;
    localparam int I_LINK = 0, I_100 = 1, I_FULL = 2, I_CACT = 3;
    localparam int I_LIGHT = 4, I_FACT = 5, I_FAR = 6;
    localparam logic [CNT_W-1:0] FLASH_LD = CNT_W'(FLASH_CYCLES_P - 1);
    localparam logic [CNT_W-1:0] FLASH_HALF = CNT_W'(FLASH_CYCLES_P / 2);

    typedef struct packed {
        logic [NUM_SW-1:0] sw_s1;
        logic [NUM_SW-1:0] sw_s2;
        logic [NIN-1:0]    in_s1;
        logic [NIN-1:0]    in_s2;
        logic [NIN-1:0]    in_d;
        logic [DLY_W-1:0]  dly;
        logic              cfg_done;
        logic [NUM_SW-1:0] cfg;
        logic [CNT_W-1:0]  cu_cnt;
        logic [CNT_W-1:0]  fx_cnt;
        logic [4:0]        led;
        logic [31:0]       ctrl;
        logic              aw_got;
        logic              w_got;
        logic [7:0]        awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } mclc_state_type;

    mclc_state_type r, n;
    logic lfp_en, lfp_down, cu_act_edge, fx_act_edge;
    logic [31:0] status_w;

    // Offset decode shared by the read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == REG_CONFIG) || (a == REG_STATUS) || (a == REG_CONTROL);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Derived link state, all from synchronised inputs
    // propagation enable from switch
    assign lfp_en   = r.cfg_done && !r.cfg[SW_PROP];
    // either segment lost shuts the path
    assign lfp_down = lfp_en && (!r.in_s2[I_LINK] || !r.in_s2[I_LIGHT]);
    assign cu_act_edge = r.in_s2[I_CACT] && !r.in_d[I_CACT];
    assign fx_act_edge = r.in_s2[I_FACT] && !r.in_d[I_FACT];

    // Live view for software
    always_comb begin
        status_w = '0;
        status_w[ST_CU_LINK]  = r.in_s2[I_LINK];
        status_w[ST_CU_100]   = r.in_s2[I_100];
        status_w[ST_CU_FULL]  = r.in_s2[I_FULL];
        status_w[ST_FX_LIGHT] = r.in_s2[I_LIGHT];
        status_w[ST_FAR_FLT]  = r.in_s2[I_FAR];
        status_w[ST_LFP_DOWN] = lfp_down;
        status_w[ST_REM_FLT]  = r.led[4];
        status_w[ST_CFG_DONE] = r.cfg_done;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n = r;
        // Two-stage synchronisers; edges seen on the second stage only
        n.sw_s1 = switch_on;
        n.sw_s2 = r.sw_s1;
        n.in_s1 = {fx_fault_rx, fx_activity, fx_light, cu_activity,
                   cu_full_duplex, cu_speed_100, cu_link_up};
        n.in_s2 = r.in_s1;
        n.in_d  = r.in_s2;
        // latch once, later moves are ignored
        if (!r.cfg_done) begin
            if (r.dly == DLY_W'(SYNC_DLY - 1)) begin
                n.cfg_done = 1'b1;
                n.cfg      = r.sw_s2;
                n.cfg[SW_UNUSED] = 1'b0;
            end else begin
                n.dly = r.dly + DLY_W'(1);
            end
        end
        // stretch each burst to a full flash
        if (r.cu_cnt != '0) begin
            n.cu_cnt = r.cu_cnt - CNT_W'(1);
        end else if (cu_act_edge) begin
            n.cu_cnt = FLASH_LD;
        end
        if (r.fx_cnt != '0) begin
            n.fx_cnt = r.fx_cnt - CNT_W'(1);
        end else if (fx_act_edge) begin
            n.fx_cnt = FLASH_LD;
        end
        // Indicators: off phase is the first half of a flash, less one cycle
        n.led = '0;
        if (r.cfg_done && r.ctrl[CTRL_LED_EN]) begin
            // link lamps dark while propagation holds the path
            if (r.in_s2[I_LINK] && !lfp_down) begin
                // colour by speed, blink on traffic
                n.led[0] = !r.in_s2[I_100] && !(r.cu_cnt > FLASH_HALF);
                n.led[1] = r.in_s2[I_100] && !(r.cu_cnt > FLASH_HALF);
                n.led[2] = r.in_s2[I_FULL];
            end
            n.led[3] = r.in_s2[I_LIGHT] && !lfp_down && !(r.fx_cnt > FLASH_HALF);
            // peer reports no light from us
            // own copper failure marks this end
            n.led[4] = r.in_s2[I_FAR] || (lfp_en && !r.in_s2[I_LINK]);
        end
        // Write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = is_mapped(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (r.awaddr == REG_CONTROL) begin
                for (int b = 0; b < 4; b++) begin
                    if (r.wstrb[b]) begin
                        n.ctrl[b*8 +: 8] = r.wdata[b*8 +: 8];
                    end
                end
            end
        end else if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // Read channel, one cycle to data
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                REG_CONFIG:  n.rdata = {{(32-NUM_SW){1'b0}}, r.cfg};
                REG_STATUS:  n.rdata = status_w;
                REG_CONTROL: n.rdata = r.ctrl;
                default:     n.rdata = '0;
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
    end

    // State register; control defaults restored on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r      <= '0;
            r.ctrl <= CTRL_RST;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready = !r.aw_got && !r.bvalid;
    assign s_axi_wready  = !r.w_got && !r.bvalid;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;

    assign cu_autoneg_en = r.cfg_done && !r.cfg[SW_NEG];
    // speed switch only in fixed mode
    assign cu_fixed_100  = r.cfg_done && r.cfg[SW_NEG] && !r.cfg[SW_SPEED];
    // duplex switch only in fixed mode
    assign cu_fixed_full = r.cfg_done && r.cfg[SW_NEG] && !r.cfg[SW_DUPLEX];
    // pause frames pass only with the switch ON
    assign pause_en      = r.cfg_done && r.cfg[SW_PAUSE];
    // fiber loss drops copper, copper loss drops fiber
    assign cu_link_enable = r.cfg_done && !(lfp_en && !r.in_s2[I_LIGHT]);
    assign fx_tx_enable   = r.cfg_done && !(lfp_en && !r.in_s2[I_LINK]);
    // report lost light back to the peer
    assign fx_fault_tx   = r.cfg_done && !r.in_s2[I_LIGHT];
    assign led_cu_yellow    = r.led[0];
    assign led_cu_green     = r.led[1];
    assign led_duplex       = r.led[2];
    assign led_fx_link      = r.led[3];
    assign led_remote_fault = r.led[4];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    cfg_frozen_a: assert property (r.cfg_done |=> r.cfg_done && $stable(r.cfg))
        else $error("configuration changed after latch");
    neg_default_a: assert property (r.cfg_done && !r.cfg[SW_NEG] |->
        cu_autoneg_en && !cu_fixed_100 && !cu_fixed_full)
        else $error("fixed settings leak into auto-negotiation");
    fixed_speed_a: assert property (r.cfg_done && r.cfg[SW_NEG] |->
        cu_fixed_100 == !r.cfg[SW_SPEED] && cu_fixed_full == !r.cfg[SW_DUPLEX])
        else $error("fixed speed or duplex wrong");
    pause_gate_a: assert property (pause_en |-> r.cfg[SW_PAUSE])
        else $error("pause enabled with switch OFF");
    local_fault_a: assert property (r.cfg_done && r.cfg[SW_PROP] |->
        cu_link_enable && fx_tx_enable)
        else $error("segment dropped with propagation off");
    prop_drop_a: assert property (lfp_en && !r.in_s2[I_LINK] |-> !fx_tx_enable)
        else $error("fiber kept on after copper loss");
    lamps_dark_a: assert property (lfp_down |=>
        !led_cu_yellow && !led_cu_green && !led_duplex && !led_fx_link)
        else $error("link lamp lit during propagation shutdown");
    own_fault_a: assert property (lfp_en && !r.in_s2[I_LINK] && r.ctrl[CTRL_LED_EN]
        |=> led_remote_fault)
        else $error("remote fault dark on own copper loss");
    far_fault_a: assert property (r.cfg_done && r.ctrl[CTRL_LED_EN] && r.in_s2[I_FAR]
        |=> led_remote_fault)
        else $error("peer fault not shown");
    no_light_a: assert property (r.cfg_done && !r.in_s2[I_LIGHT] |-> fx_fault_tx)
        else $error("lost light not reported");
    speed_colour_a: assert property (led_cu_green |-> $past(r.in_s2[I_100]))
        else $error("green lamp without 100M link");
    flash_load_a: assert property (cu_act_edge && r.cu_cnt == '0 |=> r.cu_cnt == FLASH_LD)
        else $error("activity flash not started");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");

    cfg_latch_c: cover property (!r.cfg_done ##1 r.cfg_done);
    prop_down_c: cover property (lfp_down ##1 led_remote_fault);
    cu_flash_c:  cover property (r.cu_cnt == FLASH_LD);
    ctrl_wr_c:   cover property (r.aw_got && r.w_got && r.awaddr == REG_CONTROL);
endmodule
`default_nettype wire

// ==== sim/mclc_peer_model.sv ====
// Peer converter at the far end of the fiber pair
`timescale 1ns/10ps
`default_nettype none
module mclc_peer_model (
    input  wire logic tx_cut,
    input  wire logic rx_cut,
    input  wire logic peer_cu_down,
    input  wire logic prop_on,
    input  wire logic fx_tx_enable,
    output logic      fx_light,
    output logic      fx_fault_rx
);
    //////////////////////////////////////////////////////////////////////
    // no light returns fault
    assign fx_fault_rx = !fx_tx_enable || tx_cut;
    assign fx_light = !rx_cut && !(prop_on && peer_cu_down);
endmodule
`default_nettype wire

// ==== sim/mclc_tb.sv ====
// Self-checking bench for the link control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mclc_pkg::*;
    localparam int FL = 8;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic cu_link_up = 1'b1, cu_speed_100 = 1'b1, cu_full_duplex = 1'b1, cu_activity = 1'b0;
    logic fx_activity = 1'b0, tx_cut = 1'b0, rx_cut = 1'b0, peer_cu_down = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [5:0] switch_on = 6'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic fx_light, fx_fault_rx, cu_autoneg_en, cu_fixed_100, cu_fixed_full, pause_en;
    logic cu_link_enable, fx_tx_enable, fx_fault_tx, led_cu_yellow, led_cu_green;
    logic led_duplex, led_fx_link, led_remote_fault;
    logic [34:0] exp_q[$];
    logic [34:0] mon_e;
    logic [5:0] cfg_tab [4] = '{6'h00, 6'h01, 6'h07, 6'h2e};
    int fails = 0;
    int checks = 0;

    //////////////////////////////////////////////////////////////////////
    mclc_top #(.FLASH_CYCLES_P(FL)) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .switch_on, .cu_link_up, .cu_speed_100,
        .cu_full_duplex, .cu_activity, .fx_light, .fx_activity, .fx_fault_rx, .cu_autoneg_en,
        .cu_fixed_100, .cu_fixed_full, .pause_en, .cu_link_enable, .fx_tx_enable,
        .fx_fault_tx, .led_cu_yellow, .led_cu_green, .led_duplex, .led_fx_link,
        .led_remote_fault
    );
    mclc_peer_model peer (
        .tx_cut, .rx_cut, .peer_cu_down, .prop_on(!switch_on[SW_PROP]), .fx_tx_enable,
        .fx_light, .fx_fault_rx
    );

    // Free-running bus clock
    always #25 aclk = !aclk;

    //////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk1(input string nm, input logic seen, input logic exp);
        check(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Hang guard for every handshake wait
    task automatic bound(inout int n);
        n++;
        if (n > 200) begin
            fails++;
            complete_run();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        exp_q.push_back({1'b0, r, 32'h0000_0000});
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            bound(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        exp_q.push_back({1'b1, r, d});
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            bound(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // Switches only count until the configuration latches after reset release
    task automatic do_reset(input logic [5:0] sw, input logic spd, input logic fd);
        aresetn        <= 1'b0;
        switch_on      <= sw;
        cu_speed_100   <= spd;
        cu_full_duplex <= fd;
        tick(8);
        aresetn <= 1'b1;
        tick(10);
    endtask
    // One activity pulse, then count dark lamp cycles
    task automatic flash(input bit fib);
        int dark;
        dark = 0;
        if (fib) fx_activity <= 1'b1;
        else cu_activity <= 1'b1;
        @(posedge aclk);
        cu_activity <= 1'b0;
        fx_activity <= 1'b0;
        repeat (2 * FL) begin
            @(posedge aclk);
            dark += int'(!(fib ? led_fx_link : led_cu_green));
        end
        check("dark cycles", dark, FL / 2 - 1);
        chk1("steady lamp", fib ? led_fx_link : led_cu_green, 1'b1);
    endtask

    //////////////////////////////////////////////////////////////////////
    // Response watcher: oldest note against each bus answer
    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            mon_e = exp_q.pop_front();
            if (mon_e[34]) check("rdata", s_axi_rdata, mon_e[31:0]);
            check("resp", {30'h0, mon_e[34] ? s_axi_rresp : s_axi_bresp}, {30'h0, mon_e[33:32]});
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Main sequence: mode table first, faults and registers after
    initial begin
        logic [5:0] sw;
        logic spd;
        logic fd;
        void'($urandom(51));
        for (int i = 0; i < 4; i++) begin
            sw = cfg_tab[i] | (6'($urandom_range(1)) << SW_UNUSED);
            spd = sw[SW_NEG] ? !sw[SW_SPEED] : 1'($urandom_range(1));
            fd = sw[SW_NEG] ? !sw[SW_DUPLEX] : 1'($urandom_range(1));
            do_reset(sw, spd, fd);
            chk1("autoneg", cu_autoneg_en, !sw[SW_NEG]);
            if (sw[SW_NEG]) begin
                chk1("fixed 100", cu_fixed_100, !sw[SW_SPEED]);
                chk1("fixed full", cu_fixed_full, !sw[SW_DUPLEX]);
            end
            chk1("pause", pause_en, sw[SW_PAUSE]);
            chk1("green", led_cu_green, spd);
            chk1("yellow", led_cu_yellow, !spd);
            chk1("duplex lamp", led_duplex, fd);
            axi_rd(REG_CONFIG, {26'h0, sw & 6'h2f}, RESP_OKAY);
        end
        // Local handling: only the broken segment drops
        cu_link_up <= 1'b0;
        rx_cut     <= 1'b1;
        tick(10);
        chk1("fiber tx", fx_tx_enable, 1'b1);
        chk1("copper en", cu_link_enable, 1'b1);
        chk1("fault tx", fx_fault_tx, 1'b1);
        chk1("remote lamp", led_remote_fault, 1'b0);
        cu_link_up <= 1'b1;
        rx_cut     <= 1'b0;
        do_reset(6'h00, 1'b1, 1'b1);
        switch_on <= 6'h3f;
        tick(6);
        chk1("autoneg held", cu_autoneg_en, 1'b1);
        axi_rd(REG_CONFIG, 32'h0000_0000, RESP_OKAY);
        switch_on <= 6'h00;
        flash(1'b0);
        flash(1'b1);
        tx_cut <= 1'b1;
        tick(10);
        chk1("remote lamp", led_remote_fault, 1'b1);
        tx_cut       <= 1'b0;
        peer_cu_down <= 1'b1;
        tick(10);
        chk1("remote lamp", led_remote_fault, 1'b0);
        chk1("copper en", cu_link_enable, 1'b0);
        chk1("fault tx", fx_fault_tx, 1'b1);
        chk1("fiber lamp", led_fx_link, 1'b0);
        chk1("green", led_cu_green, 1'b0);
        peer_cu_down <= 1'b0;
        cu_link_up   <= 1'b0;
        tick(12);
        chk1("fiber tx", fx_tx_enable, 1'b0);
        chk1("remote lamp", led_remote_fault, 1'b1);
        chk1("fiber lamp", led_fx_link, 1'b0);
        cu_link_up <= 1'b1;
        tick(12);
        axi_rd(REG_STATUS, 32'h0000_008f, RESP_OKAY);
        axi_rd(REG_CONTROL, CTRL_RST, RESP_OKAY);
        axi_wr(REG_CONTROL, 32'h0000_0000, RESP_OKAY);
        tick(4);
        chk1("lamps off", led_cu_green, 1'b0);
        axi_rd(REG_CONTROL, 32'h0000_0000, RESP_OKAY);
        // Lane 0 strobe low: lamp enable byte must stay untouched
        s_axi_wstrb <= 4'he;
        axi_wr(REG_CONTROL, 32'h0000_0001, RESP_OKAY);
        axi_rd(REG_CONTROL, 32'h0000_0000, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_wr(REG_CONFIG, $urandom, RESP_OKAY);
        axi_rd(REG_CONFIG, 32'h0000_0000, RESP_OKAY);
        axi_wr(8'h0c, 32'h0000_0001, RESP_SLVERR);
        axi_rd(8'h0c, 32'h0000_0000, RESP_SLVERR);
        tick(2);
        complete_run();
    end
endmodule
`default_nettype wire
